// >>> design/acdc_pkg.sv
// shared constants of the accelerometer change-detection configuration block
`default_nettype none
package acdc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_AXIS_ENABLES   = 8'h2f;
    localparam logic [7:0] ADDR_CONTROL        = 8'h30;
    localparam logic [7:0] ADDR_OUTSIDE_DBNC   = 8'h31;
    localparam logic [7:0] ADDR_INSIDE_DBNC    = 8'h32;
    // axis enable field positions
    localparam int X_OUTSIDE_BIT               = 5;
    localparam int Y_OUTSIDE_BIT               = 4;
    localparam int Z_OUTSIDE_BIT               = 3;
    localparam int X_INSIDE_BIT                = 2;
    localparam int Y_INSIDE_BIT                = 1;
    localparam int Z_INSIDE_BIT                = 0;
    // control field positions
    localparam int ENABLE_BIT                  = 7;
    localparam int REF_MODE_HI                 = 6;
    localparam int REF_MODE_LO                 = 5;
    localparam int OUTSIDE_STYLE_BIT           = 4;
    localparam int INSIDE_STYLE_BIT            = 3;
    localparam int INSIDE_COMBINE_BIT          = 2;
    localparam int VECTOR_MODE_BIT             = 1;
    localparam int MANUAL_RELOAD_BIT           = 0;
    // reset values by strap setting
    localparam logic [7:0] AXIS_RESET_GND      = 8'h00;
    localparam logic [7:0] AXIS_RESET_VDD      = 8'h38;
    localparam logic [7:0] CONTROL_RESET_GND   = 8'h00;
    localparam logic [7:0] CONTROL_RESET_VDD   = 8'hd8;
    localparam logic [7:0] DBNC_RESET          = 8'h00;
    // reference update modes
    localparam logic [1:0] REF_ON_EVENT        = 2'b00;
    localparam logic [1:0] REF_HOLD            = 2'b01;
    localparam logic [1:0] REF_SLOPE           = 2'b10;
    localparam logic [1:0] REF_ABSOLUTE        = 2'b11;
    // sample width and strap settle count
    localparam int SAMPLE_W                    = 12;
    localparam logic [1:0] BOOT_SETTLE         = 2'h2;
endpackage : acdc_pkg
`default_nettype wire

// >>> design/acdc_debounce.sv
// debounce counter for one window-comparator result
`default_nettype none
module acdc_debounce (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       tick_in,
    input  wire logic       clear_in,
    input  wire logic       cond_in,
    input  wire logic       style_in,
    input  wire logic [7:0] count_in,
    output logic            flag_out,
    output logic            rise_out
);
    import acdc_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       flag;
    } acdc_dbnc_t;

    acdc_dbnc_t st_q;
    acdc_dbnc_t st_d;

    // count up while true, decrement or clear while false
    always_comb begin
        st_d = st_q;
        if (clear_in) begin
            st_d.cnt  = 8'h00;
            st_d.flag = 1'b0;
        end else if (tick_in) begin
            if (cond_in) begin
                if (st_q.cnt < count_in) begin
                    st_d.cnt = st_q.cnt + 8'h01;
                end
                // a count lowered below the running value still fires
                if (st_d.cnt >= count_in) begin
                    st_d.flag = 1'b1;
                end
            end else if (style_in) begin
                st_d.cnt  = 8'h00;                          // [R12] [R16]
                st_d.flag = 1'b0;
            end else if (st_q.cnt != 8'h00) begin
                st_d.cnt = st_q.cnt - 8'h01;                // [R10] [R16]
            end else begin
                st_d.flag = 1'b0;                           // [R11]
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_out = st_q.flag;
    // rise seen in the evaluating cycle so the same sample can be captured
    assign rise_out = st_d.flag & ~st_q.flag;

    AST_DECREMENT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R10] [R16]
        tick_in && !clear_in && !cond_in && !style_in && st_q.cnt != 8'h00
        |=> st_q.cnt == $past(st_q.cnt) - 8'h01)
        else $error("debounce count did not step down");
    AST_CLEAR_STYLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R12]
        tick_in && !cond_in && style_in |=> st_q.cnt == 8'h00 && !flag_out)
        else $error("debounce count not cleared on false result");
    AST_SET_AT_COUNT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R11]
        tick_in && !clear_in && cond_in && ({1'b0, st_q.cnt} + 9'h001 >= {1'b0, count_in})
        |=> flag_out)
        else $error("event flag not set at programmed count");
    AST_HOLD_FALSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R11]
        flag_out && tick_in && !clear_in && !cond_in && !style_in && st_q.cnt != 8'h00
        |=> flag_out)
        else $error("event flag dropped before count plus one false periods");
endmodule : acdc_debounce
`default_nettype wire

// >>> design/acdc_change_detect.sv
// change-detection window comparator configuration, references and debounce
// Operation
// [R1] y and z outside-window enables at bits 4,3
// [R2] x,y,z inside-window enables at bits 2,1,0
// [R3] enable bit 7 low gates function off
// [R4] enable default follows strap and motion option
// [R5] enabling initialises references per update mode
// [R6] mode 00: first sample, reload on event rise
// [R7] mode 01: first sample, then hold until reload
// [R8] mode 10: reference follows every evaluated sample
// [R9] mode 11: references fixed at zero
// [R10] outside style 0: false result decrements counter
// [R11] flag after count; count+1 false periods rearm
// [R12] outside style 1: false result clears counter
// [R13] inside combine: 0 is and, 1 is or
// [R14] vector mode uses x channel only
// [R15] manual reload within one period, self-clearing
// [R16] inside style selects decrement or clear
// [R17] one evaluation per sample while enabled, active
`default_nettype none
module acdc_change_detect (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          boot_strap_select_in,
    input  wire logic                          motion_wake_option_in,
    input  wire logic                          sensor_active_in,
    input  wire logic                          sample_tick_in,
    input  wire logic [acdc_pkg::SAMPLE_W-1:0] sample_x_in,
    input  wire logic [acdc_pkg::SAMPLE_W-1:0] sample_y_in,
    input  wire logic [acdc_pkg::SAMPLE_W-1:0] sample_z_in,
    input  wire logic [acdc_pkg::SAMPLE_W-1:0] upper_threshold_in,
    input  wire logic [acdc_pkg::SAMPLE_W-1:0] lower_threshold_in,
    input  wire logic [7:0]                    reg_addr_in,
    input  wire logic [7:0]                    reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [7:0]                    reg_rdata_out,
    output logic                               func_clock_enable_out,
    output logic      [acdc_pkg::SAMPLE_W-1:0] ref_x_out,
    output logic      [acdc_pkg::SAMPLE_W-1:0] ref_y_out,
    output logic      [acdc_pkg::SAMPLE_W-1:0] ref_z_out,
    output logic                               outside_event_active_flag_out,
    output logic                               inside_event_active_flag_out
);
    import acdc_pkg::*;

    typedef struct packed {
        logic [7:0]          axis_en;
        logic [7:0]          ctrl;
        logic [7:0]          out_count;
        logic [7:0]          in_count;
        logic [SAMPLE_W-1:0] ref_x;
        logic [SAMPLE_W-1:0] ref_y;
        logic [SAMPLE_W-1:0] ref_z;
        logic                first_pending;
        logic                en_prev;
        logic                strap_s1;
        logic                strap_s2;
        logic                mot_s1;
        logic                mot_s2;
        logic [1:0]          boot_wait;
        logic                boot_done;
        logic [7:0]          rdata;
        logic                clk_en;
    } acdc_state_t;

    acdc_state_t st_q;
    acdc_state_t st_d;

    logic                       enabled;
    logic                       eval;
    logic                       vec_mode;
    logic [1:0]                 ref_mode;
    logic [SAMPLE_W-1:0]        smp     [3];
    logic [SAMPLE_W-1:0]        refv    [3];
    logic [2:0]                 axis_out;
    logic [2:0]                 axis_in;
    logic [2:0]                 out_en;
    logic [2:0]                 in_en;
    logic                       ot_cond;
    logic                       wt_cond;
    logic                       ot_flag;
    logic                       ot_rise;
    logic                       wt_flag;
    logic                       load_ref;

    // function runs only after the strap defaults are in place
    assign enabled  = st_q.ctrl[ENABLE_BIT] & st_q.boot_done;                     // [R3]
    assign eval     = enabled & sensor_active_in & sample_tick_in;               // [R17]
    assign vec_mode = st_q.ctrl[VECTOR_MODE_BIT];
    assign ref_mode = st_q.ctrl[REF_MODE_HI:REF_MODE_LO];
    assign smp[0]   = sample_x_in;
    assign smp[1]   = sample_y_in;
    assign smp[2]   = sample_z_in;
    assign refv[0]  = st_q.ref_x;
    assign refv[1]  = st_q.ref_y;
    assign refv[2]  = st_q.ref_z;

    // per-axis window compare on sample minus reference, wrapping at 12 bits
    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic signed [SAMPLE_W-1:0] delta;
        assign delta = $signed(smp[a] - refv[a]);
        assign axis_out[a] = (delta > $signed(upper_threshold_in)) ||
                             (delta < $signed(lower_threshold_in));
        assign axis_in[a]  = (delta < $signed(upper_threshold_in)) &&
                             (delta > $signed(lower_threshold_in));
    end

    // vector magnitude arrives on x; y and z drop out of both windows
    assign out_en = {st_q.axis_en[Z_OUTSIDE_BIT] & ~vec_mode,                    // [R1] [R14]
                     st_q.axis_en[Y_OUTSIDE_BIT] & ~vec_mode,
                     st_q.axis_en[X_OUTSIDE_BIT]};
    assign in_en  = {st_q.axis_en[Z_INSIDE_BIT] & ~vec_mode,                     // [R2] [R14]
                     st_q.axis_en[Y_INSIDE_BIT] & ~vec_mode,
                     st_q.axis_en[X_INSIDE_BIT]};
    assign ot_cond = |(axis_out & out_en);
    // and over no enabled axis reads false, so an empty set never fires
    assign wt_cond = st_q.ctrl[INSIDE_COMBINE_BIT] ? |(axis_in & in_en) :        // [R13]
                     ((in_en != 3'b000) && ((axis_in & in_en) == in_en));

    // outside-window debounce
    acdc_debounce u_outside (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .tick_in    (eval),
        .clear_in   (~enabled),
        .cond_in    (ot_cond),
        .style_in   (st_q.ctrl[OUTSIDE_STYLE_BIT]),                               // [R10] [R12]
        .count_in   (st_q.out_count),
        .flag_out   (ot_flag),
        .rise_out   (ot_rise)
    );

    // inside-window debounce
    acdc_debounce u_inside (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .tick_in    (eval),
        .clear_in   (~enabled),
        .cond_in    (wt_cond),
        .style_in   (st_q.ctrl[INSIDE_STYLE_BIT]),                                // [R16]
        .count_in   (st_q.in_count),
        .flag_out   (wt_flag),
        .rise_out   ()
    );

    // which reference load happens on this evaluation
    always_comb begin
        load_ref = 1'b0;
        case (ref_mode)
            REF_ON_EVENT: load_ref = st_q.first_pending | ot_rise |               // [R6]
                                     st_q.ctrl[MANUAL_RELOAD_BIT];
            REF_HOLD:     load_ref = st_q.first_pending |                         // [R7]
                                     st_q.ctrl[MANUAL_RELOAD_BIT];
            REF_SLOPE:    load_ref = 1'b1;                                        // [R8]
            REF_ABSOLUTE: load_ref = 1'b0;                                        // [R9]
            default:      load_ref = 1'b0;
        endcase
    end

    // strap capture, register writes, reference update
    always_comb begin
        st_d          = st_q;
        st_d.strap_s1 = boot_strap_select_in;
        st_d.strap_s2 = st_q.strap_s1;
        st_d.mot_s1   = motion_wake_option_in;
        st_d.mot_s2   = st_q.mot_s1;
        if (!st_q.boot_done) begin
            if (st_q.boot_wait == BOOT_SETTLE) begin
                st_d.boot_done = 1'b1;
                st_d.axis_en   = st_q.strap_s2 ? AXIS_RESET_VDD : AXIS_RESET_GND;
                st_d.ctrl      = CONTROL_RESET_GND;                               // [R4]
                if (st_q.strap_s2) begin
                    st_d.ctrl = CONTROL_RESET_VDD;
                    st_d.ctrl[ENABLE_BIT] = st_q.mot_s2;                          // [R4]
                end
            end else begin
                st_d.boot_wait = st_q.boot_wait + 2'h1;
            end
        end else begin
            if (eval) begin
                // reload request is consumed by this evaluation, absolute mode too
                st_d.ctrl[MANUAL_RELOAD_BIT] = 1'b0;                              // [R15]
                st_d.first_pending = 1'b0;
                if (ref_mode == REF_ABSOLUTE) begin
                    st_d.ref_x = '0;                                              // [R9]
                    st_d.ref_y = '0;
                    st_d.ref_z = '0;
                end else if (load_ref) begin
                    st_d.ref_x = sample_x_in;                                     // [R5]
                    st_d.ref_y = sample_y_in;
                    st_d.ref_z = sample_z_in;
                end
            end
            if (reg_wr_in) begin
                case (reg_addr_in)
                    ADDR_AXIS_ENABLES: st_d.axis_en   = reg_wdata_in;
                    ADDR_OUTSIDE_DBNC: st_d.out_count = reg_wdata_in;
                    ADDR_INSIDE_DBNC:  st_d.in_count  = reg_wdata_in;
                    ADDR_CONTROL: begin
                        st_d.ctrl[7:1] = reg_wdata_in[7:1];
                        // a new request wins over the clear of an old one
                        if (reg_wdata_in[MANUAL_RELOAD_BIT]) begin
                            st_d.ctrl[MANUAL_RELOAD_BIT] = 1'b1;                  // [R15]
                        end
                    end
                    default: st_d.ctrl = st_d.ctrl;
                endcase
            end
        end
        // a fresh enable arms the first-sample capture
        st_d.en_prev = st_d.ctrl[ENABLE_BIT] & st_d.boot_done;
        if (st_d.en_prev && !st_q.en_prev) begin
            st_d.first_pending = 1'b1;                                            // [R5]
        end
        st_d.clk_en = st_d.en_prev;                                               // [R3]
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_AXIS_ENABLES: st_d.rdata = st_q.axis_en;
                ADDR_CONTROL:      st_d.rdata = st_q.ctrl;
                ADDR_OUTSIDE_DBNC: st_d.rdata = st_q.out_count;
                ADDR_INSIDE_DBNC:  st_d.rdata = st_q.in_count;
                default:           st_d.rdata = 8'h00;
            endcase
        end
    end

    // state register; strap defaults land after release, not under reset
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q           <= '0;
            st_q.out_count <= DBNC_RESET;
            st_q.in_count  <= DBNC_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_out                 = st_q.rdata;
    assign func_clock_enable_out         = st_q.clk_en;
    assign ref_x_out                     = st_q.ref_x;
    assign ref_y_out                     = st_q.ref_y;
    assign ref_z_out                     = st_q.ref_z;
    assign outside_event_active_flag_out = ot_flag;
    assign inside_event_active_flag_out  = wt_flag;

    AST_R1_Y_ONLY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R1]
        st_q.axis_en[5:3] == 3'b010 && !vec_mode |-> ot_cond == axis_out[1])
        else $error("outside result not driven by y alone");
    AST_R2_Z_ONLY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R2]
        st_q.axis_en[2:0] == 3'b001 && !vec_mode |-> wt_cond == axis_in[2])
        else $error("inside result not driven by z alone");
    AST_R3_GATED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R3]
        !st_q.ctrl[ENABLE_BIT] |-> !func_clock_enable_out ##1 !outside_event_active_flag_out)
        else $error("function still clocked while disabled");
    AST_R4_STRAP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R4]
        $rose(st_q.boot_done) |-> st_q.ctrl[ENABLE_BIT] == ($past(st_q.strap_s2) &&
        $past(st_q.mot_s2)))
        else $error("enable default does not follow strap");
    AST_R5_ARM: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R5]
        $rose(enabled) |-> st_q.first_pending)
        else $error("first-sample capture not armed on enable");
    AST_R6_EVENT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R6]
        eval && ref_mode == REF_ON_EVENT && ot_rise |=> ref_y_out == $past(sample_y_in))
        else $error("reference not reloaded on event rise");
    AST_R7_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R7]
        ref_mode == REF_HOLD && !st_q.first_pending && !st_q.ctrl[MANUAL_RELOAD_BIT]
        && enabled && !reg_wr_in |=> $stable(ref_x_out) && $stable(ref_z_out))
        else $error("held reference changed");
    AST_R8_SLOPE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R8]
        eval && ref_mode == REF_SLOPE |=> ref_z_out == $past(sample_z_in))
        else $error("slope reference not following sample");
    AST_R9_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R9]
        eval && ref_mode == REF_ABSOLUTE |=> ref_x_out == '0 && ref_y_out == '0)
        else $error("absolute mode reference not zero");
    AST_R13_OR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R13]
        st_q.ctrl[INSIDE_COMBINE_BIT] && st_q.axis_en[2:0] == 3'b111 && !vec_mode
        |-> wt_cond == |axis_in)
        else $error("inside or-combine wrong");
    AST_R14_VECTOR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R14]
        vec_mode |-> ot_cond == (axis_out[0] && st_q.axis_en[X_OUTSIDE_BIT]))
        else $error("vector mode looked past x");
    AST_R15_RELOAD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R15]
        eval && st_q.ctrl[MANUAL_RELOAD_BIT] && ref_mode != REF_ABSOLUTE && !reg_wr_in
        |=> ref_x_out == $past(sample_x_in) && !st_q.ctrl[MANUAL_RELOAD_BIT])
        else $error("manual reload not done or not self-cleared");
    AST_R17_IDLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R17]
        st_q.boot_done && !sensor_active_in ##1 !sensor_active_in
        |-> $stable(ref_x_out) && $stable(ref_y_out))
        else $error("reference moved while sensor inactive");

    COV_EVENT_RISE:  cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        eval && ot_rise);
    COV_MANUAL:      cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        eval && st_q.ctrl[MANUAL_RELOAD_BIT] && ref_mode == REF_HOLD);
    COV_INSIDE_FLAG: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(inside_event_active_flag_out));
    COV_VECTOR:      cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        eval && vec_mode);
    COV_SLOPE:       cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        eval && ref_mode == REF_SLOPE);

    // disabled function freezes refs; clear styles drop flags at once
    AST_R3_FROZEN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R3]
        !enabled |=> $stable(ref_x_out) && $stable(ref_z_out))
        else $error("reference moved while function disabled");
    AST_R12_OUT_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R12]
        eval && !ot_cond && st_q.ctrl[OUTSIDE_STYLE_BIT] |=> !outside_event_active_flag_out)
        else $error("outside flag kept after false result in clear style");
    AST_R14_VEC_INSIDE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R14]
        vec_mode && !st_q.ctrl[INSIDE_COMBINE_BIT] && st_q.axis_en[X_INSIDE_BIT]
        |-> wt_cond == axis_in[0])
        else $error("vector mode inside result looked past x");
    AST_R16_IN_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [R16]
        eval && !wt_cond && st_q.ctrl[INSIDE_STYLE_BIT] |=> !inside_event_active_flag_out)
        else $error("inside flag kept after false result in clear style");
endmodule : acdc_change_detect
`default_nettype wire

// >>> dv/acdc_sample_src.sv
// sample source model feeding triplets to the change detector
`default_nettype none
module acdc_sample_src (
    input  wire logic                          sys_clk_in,
    output logic                               tick_out,
    output logic      [acdc_pkg::SAMPLE_W-1:0] x_out,
    output logic      [acdc_pkg::SAMPLE_W-1:0] y_out,
    output logic      [acdc_pkg::SAMPLE_W-1:0] z_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import acdc_pkg::*;
    // idle at time zero
    initial begin
        tick_out = 1'b0;
        {x_out, y_out, z_out} = '0;
    end
    // one triplet per one-cycle tick, then settle a cycle
    task automatic send(input logic [3*SAMPLE_W-1:0] t);
        @(negedge sys_clk_in);
        tick_out = 1'b1;
        {x_out, y_out, z_out} = t;
        @(negedge sys_clk_in);
        tick_out = 1'b0;
        // stale data must never pass for a sample
        {x_out, y_out, z_out} = ~t;
        @(negedge sys_clk_in);
    endtask : send
endmodule : acdc_sample_src
`default_nettype wire

// >>> dv/acdc_change_detect_bench.sv
// self-checking bench of the change-detection configuration block
`default_nettype none
module acdc_change_detect_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import acdc_pkg::*;
    logic        clk, rst_n, strap, opt, act, wr, rd, tick, fce, ofl, ifl;
    logic [7:0]  addr, wdata, rdata;
    logic [11:0] sx, sy, sz, rx, ry, rz, up_th, lo_th;
    logic [35:0] a, b, c;
    int          failures, n_checks, m, k;
    acdc_sample_src src (.sys_clk_in(clk), .tick_out(tick), .x_out(sx), .y_out(sy), .z_out(sz));
    // window limits start at +10 and -10
    acdc_change_detect uut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .boot_strap_select_in(strap),
        .motion_wake_option_in(opt), .sensor_active_in(act), .sample_tick_in(tick),
        .sample_x_in(sx), .sample_y_in(sy), .sample_z_in(sz),
        .upper_threshold_in(up_th), .lower_threshold_in(lo_th),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .func_clock_enable_out(fce), .ref_x_out(rx),
        .ref_y_out(ry), .ref_z_out(rz), .outside_event_active_flag_out(ofl),
        .inside_event_active_flag_out(ifl));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude;
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // write, plus a cycle so registered effects land
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask : wreg
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        @(negedge clk);
        addr = ad;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(36'(rdata), 36'(e));
    endtask : rchk
    task automatic boot(input logic s, input logic o);
        rst_n = 1'b0;
        strap = s;
        opt = o;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : boot
    function automatic logic [7:0] ctl_default(input logic s, input logic o);
        return s ? (o ? CONTROL_RESET_VDD : (CONTROL_RESET_VDD & 8'h7f)) : CONTROL_RESET_GND;
    endfunction : ctl_default
    // refs: zero when absolute, latest when slope, else first capture
    function automatic logic [35:0] ref_exp(input int md, input logic [35:0] f, cur);
        return (md == 3) ? 36'h0 : ((md == 2) ? cur : f);
    endfunction : ref_exp
    // watchdog: a hang counts as a failure
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        conclude;
    end
    // main sequence
    initial begin
        {rst_n, strap, opt, wr, rd, addr, wdata} = '0;
        act = 1'b1;
        {up_th, lo_th} = {12'h00a, 12'hff6};
        failures = 0;
        n_checks = 0;
        void'($urandom(94831));
        for (k = 2; k >= 0; k--) begin
            boot(k > 0, k == 2);
            rchk(ADDR_AXIS_ENABLES, (k > 0) ? AXIS_RESET_VDD : AXIS_RESET_GND);
            rchk(ADDR_CONTROL, ctl_default(k > 0, k == 2));
            rchk(8'h40, 8'h00);
            chk(36'(fce), 36'(k == 2));
        end
        // every reference mode: capture, follow, idle sensor, manual reload
        for (m = 0; m < 4; m++) begin
            wreg(ADDR_CONTROL, 8'h00);
            chk(36'(fce), 36'h0);
            wreg(ADDR_CONTROL, 8'(8'h80 | (m << 5)));
            chk(36'(fce), 36'h1);
            a = {4'($urandom()), 32'($urandom())};
            b = {4'($urandom()), 32'($urandom())};
            c = {4'($urandom()), 32'($urandom())};
            src.send(a);
            chk({rx, ry, rz}, ref_exp(m, a, a));
            src.send(b);
            chk({rx, ry, rz}, ref_exp(m, a, b));
            act = 1'b0;
            src.send(~b);
            act = 1'b1;
            chk({rx, ry, rz}, ref_exp(m, a, b));
            wreg(ADDR_CONTROL, 8'(8'h81 | (m << 5)));
            rchk(ADDR_CONTROL, 8'(8'h81 | (m << 5)));
            src.send(c);
            chk({rx, ry, rz}, ref_exp(m, c, c));
            rchk(ADDR_CONTROL, 8'(8'h80 | (m << 5)));
        end
        // outside debounce, y axis only, count 2, decrement style
        wreg(ADDR_CONTROL, 8'h00);
        wreg(ADDR_AXIS_ENABLES, 8'h10);
        wreg(ADDR_OUTSIDE_DBNC, 8'h02);
        wreg(ADDR_CONTROL, 8'h80);
        src.send(36'h0);
        src.send(36'h0_0000_0064);
        chk(36'(ofl), 36'h0);
        src.send(36'h0_0006_4000);
        chk(36'(ofl), 36'h0);
        src.send(36'h0_0006_4000);
        chk(36'(ofl), 36'h1);
        chk({rx, ry, rz}, 36'h0_0006_4000);
        for (k = 0; k < 3; k++) begin
            src.send(36'h0_0006_4000);
            chk(36'(ofl), 36'(k < 2));
        end
        // clear style: one false period drops the flag
        wreg(ADDR_CONTROL, 8'h90);
        src.send(36'h0);
        src.send(36'h0);
        chk(36'(ofl), 36'h1);
        src.send(36'h0);
        chk(36'(ofl), 36'h0);
        // inside window: and, then or, count 0
        wreg(ADDR_AXIS_ENABLES, 8'h07);
        src.send(36'h0);
        chk(36'(ifl), 36'h1);
        src.send(36'h0_6400_0000);
        chk(36'(ifl), 36'h0);
        wreg(ADDR_CONTROL, 8'h94);
        src.send(36'h0_6400_0000);
        chk(36'(ifl), 36'h1);
        // vector mode: only x counts, so z far outside keeps the and true
        wreg(ADDR_CONTROL, 8'h92);
        src.send(36'h0_0000_0064);
        chk(36'(ifl), 36'h1);
        // wider window with clear-style inside debounce
        wreg(ADDR_CONTROL, 8'h98);
        up_th = 12'h0c8;
        src.send(36'h0_0000_0064);
        chk(36'(ifl), 36'h1);
        src.send(36'h1_2c00_0000);
        chk(36'(ifl), 36'h0);
        conclude;
    end
endmodule : acdc_change_detect_bench
`default_nettype wire
